// [clock_prescaler.sv]
// Slow-mode divider that makes the cpu clock enable from the oscillator clock
`timescale 1ns/1ps
`include "misc_ctrl_cfg.svh"

module clock_prescaler (
    input  wire logic                        sys_clk,
    input  wire logic                        rst,
    input  wire logic                        slow_select,
    input  wire misc_ctrl_pkg::sense_t       cpu_prescale_sel,
    output logic                             cpu_clock_en
);
    misc_ctrl_pkg::div_count_t count;
    misc_ctrl_pkg::div_count_t next_count;
    misc_ctrl_pkg::div_count_t last;

    // ************************************************************
    // Divider
    // ************************************************************
    always_comb begin
        unique case (cpu_prescale_sel)
            `PRESCALE_DIV2:  last = `DIV2_LAST;
            `PRESCALE_DIV4:  last = `DIV4_LAST;
            `PRESCALE_DIV8:  last = `DIV8_LAST;
            `PRESCALE_DIV16: last = `DIV16_LAST;
        endcase
        // Counter held at zero in normal mode so slow mode starts on a full period
        if (!slow_select || count >= last) begin
            next_count = 4'h0;
        end else begin
            next_count = count + 4'h1;
        end
        cpu_clock_en = !slow_select || (count == last);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            count <= 4'h0;
        end else begin
            count <= next_count;
        end
    end

    a_div_period: assert property (@(posedge sys_clk) disable iff (rst)
        slow_select && cpu_prescale_sel == `PRESCALE_DIV16 && count == 4'h0
        && $stable(cpu_prescale_sel) |-> !cpu_clock_en)
        else $error("Divide by 16 gave an early cpu clock enable");
endmodule : clock_prescaler

// [misc_ctrl_cfg.svh]
// Register map, field positions, reset values and encodings of the misc control bank
`ifndef MISC_CTRL_CFG_SVH
`define MISC_CTRL_CFG_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define IRQ_SENSE_CLOCK_CTRL_ADDR 8'h20
`define SPI_PIN_CTRL_LEGACY_ADDR  8'h40

// ************************************************************
// Field positions
// ************************************************************
`define GROUP_B_SENSE_HI          7
`define GROUP_B_SENSE_LO          6
`define CLOCK_OUT_SELECT_BIT      5
`define GROUP_A_SENSE_HI          4
`define GROUP_A_SENSE_LO          3
`define CPU_PRESCALE_HI           2
`define CPU_PRESCALE_LO           1
`define SLOW_SELECT_BIT           0
`define MASTER_OUT_DISABLE_BIT    3
`define SLAVE_OUT_DISABLE_BIT     2
`define SELECT_SOURCE_MODE_BIT    1
`define INTERNAL_SELECT_LEVEL_BIT 0

// ************************************************************
// Reset values and fixed codes
// ************************************************************
`define IRQ_SENSE_CLOCK_CTRL_RST  8'h00
`define SPI_PIN_CTRL_LEGACY_RST   4'h0
`define READ_ZERO                 8'h00
`define IRQ_MASK_ALL_SET          2'h3
`define SENSE_FALL_LOW            2'h0
`define SENSE_RISE                2'h1
`define SENSE_FALL                2'h2
`define SENSE_BOTH                2'h3
`define PRESCALE_DIV2             2'h0
`define PRESCALE_DIV8             2'h1
`define PRESCALE_DIV4             2'h2
`define PRESCALE_DIV16            2'h3
`define DIV2_LAST                 4'h1
`define DIV4_LAST                 4'h3
`define DIV8_LAST                 4'h7
`define DIV16_LAST                4'hf

`endif

// [misc_ctrl_pkg.sv]
// Shared types of the misc control bank
package misc_ctrl_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [1:0] sense_t;
    typedef logic [3:0] div_count_t;
endpackage : misc_ctrl_pkg

// [misc_irq_clock_spi_ctrl.sv]
// Interrupt sensitivity, clock-out, slow-mode and legacy spi pin control bank
// Functional notes
// - Bits 7:6 of the first register pick the event of group B: low level, rise, fall, both.
// - Bits 4:3 of the first register pick the event of group A with the same encoding.
// - Both sense fields take a write only while both cpu interrupt mask bits are one.
// - Group B listens to port B, group A to port A, and port C joins one group by option.
// - With bit 5 set the cpu clock goes out on port C pin 2, otherwise that pin is plain I/O.
// - Bits 2:1 divide the oscillator in slow mode: 00 by 2, 10 by 4, 01 by 8, 11 by 16.
// - Bit 0 clear gives the cpu the oscillator clock, set gives the divided clock.
// - Bit 3 of the second register kills the spi master data output driver.
// - Bit 2 of the second register kills the spi slave data output driver.
// - Bit 1 of the second register takes the spi select level from bit 0 instead of the pin.
// - With internal select the pin is not fed to the spi, so port B pin 7 stays plain I/O.
// - The upper four bits of the second register read zero and all fields reset to zero.
// - A pin raises an interrupt only when set up as an interrupt input and not masked.
`timescale 1ns/1ps
`include "misc_ctrl_cfg.svh"

module misc_irq_clock_spi_ctrl (
    input  wire logic                        sys_clk,
    input  wire logic                        rst,
    // Register port
    input  wire misc_ctrl_pkg::byte_t        reg_addr,
    input  wire misc_ctrl_pkg::byte_t        reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output misc_ctrl_pkg::byte_t             reg_rdata,
    // Cpu interrupt mask and routing option
    input  wire logic [1:0]                  condition_code_reg,
    input  wire logic                        ext_irq_route_option,
    // Port pins and their direction and option bits
    input  wire logic [7:0]                  port_a_in,
    input  wire logic [7:0]                  port_a_ddr,
    input  wire logic [7:0]                  port_a_opt,
    input  wire logic [7:0]                  port_b_in,
    input  wire logic [7:0]                  port_b_ddr,
    input  wire logic [7:0]                  port_b_opt,
    input  wire logic [5:0]                  port_c_in,
    input  wire logic [5:0]                  port_c_ddr,
    input  wire logic [5:0]                  port_c_opt,
    output logic                             ext_irq_group_a,
    output logic                             ext_irq_group_b,
    // Cpu clock and its output pin
    output logic                             cpu_clock_en,
    input  wire logic                        port_c_pin2_gpio_out,
    input  wire logic                        port_c_pin2_gpio_oe,
    output logic                             port_c_pin2_out,
    output logic                             port_c_pin2_oe,
    // Spi pin control
    input  wire logic                        spi_mosi_oe,
    input  wire logic                        spi_miso_oe,
    input  wire logic                        spi_select_pin_n,
    output logic                             mosi_pad_oe,
    output logic                             miso_pad_oe,
    output logic                             spi_select_n
);
    // ************************************************************
    // Register state
    // ************************************************************
    misc_ctrl_pkg::sense_t group_b_sense;
    misc_ctrl_pkg::sense_t group_a_sense;
    logic                  clock_out_select;
    misc_ctrl_pkg::sense_t cpu_prescale_sel;
    logic                  slow_select;
    logic                  master_out_disable;
    logic                  slave_out_disable;
    logic                  select_source_mode;
    logic                  internal_select_level;

    misc_ctrl_pkg::sense_t next_group_b_sense;
    misc_ctrl_pkg::sense_t next_group_a_sense;
    logic                  next_clock_out_select;
    misc_ctrl_pkg::sense_t next_cpu_prescale_sel;
    logic                  next_slow_select;
    logic                  next_master_out_disable;
    logic                  next_slave_out_disable;
    logic                  next_select_source_mode;
    logic                  next_internal_select_level;
    misc_ctrl_pkg::byte_t  next_reg_rdata;

    logic                  sense_write_ok;
    logic                  wr_reg1;
    logic                  wr_reg2;
    misc_ctrl_pkg::byte_t  reg1_view;
    misc_ctrl_pkg::byte_t  reg2_view;

    always_comb begin
        sense_write_ok = (condition_code_reg == `IRQ_MASK_ALL_SET);
        wr_reg1        = reg_wr && (reg_addr == `IRQ_SENSE_CLOCK_CTRL_ADDR);
        wr_reg2        = reg_wr && (reg_addr == `SPI_PIN_CTRL_LEGACY_ADDR);
        reg1_view      = {group_b_sense, clock_out_select, group_a_sense,
                          cpu_prescale_sel, slow_select};
        reg2_view      = {`SPI_PIN_CTRL_LEGACY_RST, master_out_disable,
                          slave_out_disable, select_source_mode,
                          internal_select_level};

        next_group_b_sense         = group_b_sense;
        next_group_a_sense         = group_a_sense;
        next_clock_out_select      = clock_out_select;
        next_cpu_prescale_sel      = cpu_prescale_sel;
        next_slow_select           = slow_select;
        next_master_out_disable    = master_out_disable;
        next_slave_out_disable     = slave_out_disable;
        next_select_source_mode    = select_source_mode;
        next_internal_select_level = internal_select_level;

        if (wr_reg1) begin
            // Sense fields hold their value when the cpu has not masked interrupts
            if (sense_write_ok) begin
                next_group_b_sense = reg_wdata[`GROUP_B_SENSE_HI:`GROUP_B_SENSE_LO];
                next_group_a_sense = reg_wdata[`GROUP_A_SENSE_HI:`GROUP_A_SENSE_LO];
            end
            next_clock_out_select = reg_wdata[`CLOCK_OUT_SELECT_BIT];
            next_cpu_prescale_sel = reg_wdata[`CPU_PRESCALE_HI:`CPU_PRESCALE_LO];
            next_slow_select      = reg_wdata[`SLOW_SELECT_BIT];
        end
        if (wr_reg2) begin
            next_master_out_disable    = reg_wdata[`MASTER_OUT_DISABLE_BIT];
            next_slave_out_disable     = reg_wdata[`SLAVE_OUT_DISABLE_BIT];
            next_select_source_mode    = reg_wdata[`SELECT_SOURCE_MODE_BIT];
            next_internal_select_level = reg_wdata[`INTERNAL_SELECT_LEVEL_BIT];
        end

        // Read data stand only in the cycle after the strobe; unmapped reads give zero
        next_reg_rdata = `READ_ZERO;
        if (reg_rd && reg_addr == `IRQ_SENSE_CLOCK_CTRL_ADDR) begin
            next_reg_rdata = reg1_view;
        end else if (reg_rd && reg_addr == `SPI_PIN_CTRL_LEGACY_ADDR) begin
            next_reg_rdata = reg2_view;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            group_b_sense         <= 2'h0;
            group_a_sense         <= 2'h0;
            clock_out_select      <= 1'h0;
            cpu_prescale_sel      <= 2'h0;
            slow_select           <= 1'h0;
            master_out_disable    <= 1'h0;
            slave_out_disable     <= 1'h0;
            select_source_mode    <= 1'h0;
            internal_select_level <= 1'h0;
            reg_rdata             <= `READ_ZERO;
        end else begin
            group_b_sense         <= next_group_b_sense;
            group_a_sense         <= next_group_a_sense;
            clock_out_select      <= next_clock_out_select;
            cpu_prescale_sel      <= next_cpu_prescale_sel;
            slow_select           <= next_slow_select;
            master_out_disable    <= next_master_out_disable;
            slave_out_disable     <= next_slave_out_disable;
            select_source_mode    <= next_select_source_mode;
            internal_select_level <= next_internal_select_level;
            reg_rdata             <= next_reg_rdata;
        end
    end

    // ************************************************************
    // External interrupt groups
    // ************************************************************
    logic [13:0] group_a_pins;
    logic [13:0] group_a_qual;
    logic [13:0] group_b_pins;
    logic [13:0] group_b_qual;
    logic        irq_allow;
    logic [7:0]  port_a_qual;
    logic [7:0]  port_b_qual;
    logic [5:0]  port_c_qual;

    always_comb begin
        // Interrupt input means input direction with the option bit set
        port_a_qual = ~port_a_ddr & port_a_opt;
        port_b_qual = ~port_b_ddr & port_b_opt;
        port_c_qual = ~port_c_ddr & port_c_opt;
        irq_allow   = (condition_code_reg != `IRQ_MASK_ALL_SET);
        // Port C joins exactly one group so one pin never raises both vectors
        group_a_pins = {port_c_in, port_a_in};
        group_b_pins = {port_c_in, port_b_in};
        group_a_qual = {ext_irq_route_option ? 6'h00 : port_c_qual, port_a_qual};
        group_b_qual = {ext_irq_route_option ? port_c_qual : 6'h00, port_b_qual};
    end

    pin_irq_detect #(
        .WIDTH   (14)
    ) u_group_a (
        .sys_clk (sys_clk),
        .rst     (rst),
        .pins    (group_a_pins),
        .qualify (group_a_qual),
        .sense   (group_a_sense),
        .allow   (irq_allow),
        .irq     (ext_irq_group_a)
    );

    pin_irq_detect #(
        .WIDTH   (14)
    ) u_group_b (
        .sys_clk (sys_clk),
        .rst     (rst),
        .pins    (group_b_pins),
        .qualify (group_b_qual),
        .sense   (group_b_sense),
        .allow   (irq_allow),
        .irq     (ext_irq_group_b)
    );

    // ************************************************************
    // Cpu clock and clock-out pin
    // ************************************************************
    clock_prescaler u_prescaler (
        .sys_clk          (sys_clk),
        .rst              (rst),
        .slow_select      (slow_select),
        .cpu_prescale_sel (cpu_prescale_sel),
        .cpu_clock_en     (cpu_clock_en)
    );

    // Only the cpu clock enable can leave the block; a true clock would need a pad mux
    always_comb begin
        port_c_pin2_out = clock_out_select ? cpu_clock_en : port_c_pin2_gpio_out;
        port_c_pin2_oe  = clock_out_select || port_c_pin2_gpio_oe;
    end

    // ************************************************************
    // Legacy spi pin control
    // ************************************************************
    logic ss_s1;
    logic ss_s2;
    logic ss_s3;
    logic ss_level;
    logic next_ss_level;

    always_comb begin
        next_ss_level = (ss_s2 == ss_s3) ? ss_s3 : ss_level;
        mosi_pad_oe   = spi_mosi_oe && !master_out_disable;
        miso_pad_oe   = spi_miso_oe && !slave_out_disable;
        spi_select_n  = select_source_mode ? internal_select_level : ss_level;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ss_s1    <= 1'b1;
            ss_s2    <= 1'b1;
            ss_s3    <= 1'b1;
            ss_level <= 1'b1;
        end else begin
            ss_s1    <= spi_select_pin_n;
            ss_s2    <= ss_s1;
            ss_s3    <= ss_s2;
            ss_level <= next_ss_level;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    a_sense_locked: assert property (
        reg_wr && reg_addr == `IRQ_SENSE_CLOCK_CTRL_ADDR
        && condition_code_reg != `IRQ_MASK_ALL_SET
        |=> $stable(group_a_sense) && $stable(group_b_sense))
        else $error("Sense field changed while interrupts were unmasked");

    a_sense_taken: assert property (
        reg_wr && reg_addr == `IRQ_SENSE_CLOCK_CTRL_ADDR
        && condition_code_reg == `IRQ_MASK_ALL_SET
        |=> group_b_sense == $past(reg_wdata[7:6]) && group_a_sense == $past(reg_wdata[4:3]))
        else $error("Sense field not taken while interrupts were masked");

    a_reg2_upper_zero: assert property (
        $past(reg_rd) && $past(reg_addr) == `SPI_PIN_CTRL_LEGACY_ADDR
        |-> reg_rdata[7:4] == 4'h0 && reg_rdata[3:0] == {master_out_disable,
        slave_out_disable, select_source_mode, internal_select_level})
        else $error("Legacy register read back wrong");

    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("Read data outside the cycle after a read");

    a_clock_out_pin: assert property (
        clock_out_select |-> port_c_pin2_oe && port_c_pin2_out == cpu_clock_en)
        else $error("Cpu clock not on port C pin 2");

    a_normal_clock: assert property (!slow_select |-> cpu_clock_en)
        else $error("Normal mode cpu clock not every oscillator cycle");

    a_slow_div2: assert property (
        slow_select && cpu_prescale_sel == 2'h0 && cpu_clock_en
        && $stable(cpu_prescale_sel) ##1 slow_select && $stable(cpu_prescale_sel)
        |-> !cpu_clock_en ##1 (cpu_clock_en || $changed(cpu_prescale_sel)))
        else $error("Divide by 2 period wrong");

    a_mosi_gate: assert property (master_out_disable |-> !mosi_pad_oe)
        else $error("Master output driven while disabled");

    a_miso_gate: assert property (miso_pad_oe == (spi_miso_oe && !slave_out_disable))
        else $error("Slave output gating wrong");

    a_internal_select: assert property (
        select_source_mode |-> spi_select_n == internal_select_level)
        else $error("Select level not taken from the internal bit");

    a_masked_no_irq: assert property (
        condition_code_reg == `IRQ_MASK_ALL_SET [*2] |=> !ext_irq_group_a && !ext_irq_group_b)
        else $error("Interrupt request while masked");
endmodule : misc_irq_clock_spi_ctrl

// [misc_irq_clock_spi_ctrl_test.sv]
// Self-checking bench of the misc control bank
`timescale 1ns/1ps
module misc_irq_clock_spi_ctrl_test;
    logic sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, route = 0;
    logic en, ia, ib, po, poe, mo, so, sel, pia = 0, pib = 0;
    misc_ctrl_pkg::byte_t reg_addr = 0, reg_wdata = 0, rdata;
    logic [1:0] cc = 0;
    logic [2:0] low = 0;
    logic [3:0] drv = 4'hf, spi;
    logic [7:0] pa, pb, r1 = 0, opt = 8'hff, ddr = 8'h00;
    logic [5:0] pc;
    logic [31:0] seed = 32'hd873fa3e;
    int error_cnt = 0, n_checks = 0, na = 0, nb = 0, ne = 0, np = 0, sa, sb;
    misc_irq_clock_spi_ctrl i_misc_irq_clock_spi_ctrl (.sys_clk, .rst, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata(rdata), .condition_code_reg(cc),
        .ext_irq_route_option(route), .port_a_in(pa), .port_a_ddr(ddr), .port_a_opt(opt),
        .port_b_in(pb), .port_b_ddr(ddr), .port_b_opt(opt), .port_c_in(pc),
        .port_c_ddr(ddr[5:0]), .port_c_opt(opt[5:0]), .ext_irq_group_a(ia),
        .ext_irq_group_b(ib), .cpu_clock_en(en), .port_c_pin2_gpio_out(spi[3]),
        .port_c_pin2_gpio_oe(spi[0]), .port_c_pin2_out(po), .port_c_pin2_oe(poe),
        .spi_mosi_oe(spi[0]), .spi_miso_oe(spi[1]), .spi_select_pin_n(spi[2]),
        .mosi_pad_oe(mo), .miso_pad_oe(so), .spi_select_n(sel));
    misc_pin_partner i_misc_pin_partner (.sys_clk, .pull_low(low), .drv, .pa, .pb, .pc,
        .spi);
    initial forever #20 sys_clk = ~sys_clk;
    // ****************************************
    // Event counters, so a pulse is never missed between samples
    // ****************************************
    always @(posedge sys_clk) begin
        na <= na + int'(ia && !pia);
        nb <= nb + int'(ib && !pib);
        ne <= ne + int'(en);
        np <= np + int'(po !== (r1[5] ? en : spi[3]));
        pia <= ia;
        pib <= ib;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction : xs
    task automatic check(input string nm, input logic [7:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic end_of_test;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_of_test
    task automatic wr(input logic [7:0] a, d);
        @(posedge sys_clk);
        // Sense bits only move while both mask bits are set; cc is read once settled
        if (a == 8'h20) r1 = (cc == 2'h3) ? d : {r1[7:6], d[5], r1[4:3], d[2:0]};
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 check("rdata", rdata, exp);
    endtask : rd
    task automatic pulse(input int g, exa, exb);
        sa = na;
        sb = nb;
        low[g] <= 1'b1;
        repeat (8) @(posedge sys_clk);
        low[g] <= 1'b0;
        repeat (12) @(posedge sys_clk);
        check("irq_a", 8'(na - sa), 8'(exa));
        check("irq_b", 8'(nb - sb), 8'(exb));
    endtask : pulse
    initial begin
        #400000 error_cnt++;
        end_of_test();
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        rd(8'h20, 8'h00);
        rd(8'h40, 8'h00);
        rd(8'h33, 8'h00);
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            drv <= seed[3:0];
            wr(8'h40, seed[15:8]);
            repeat (6) @(posedge sys_clk);
            check("mosi_oe", 8'(mo), 8'(drv[0] & !seed[11]));
            check("miso_oe", 8'(so), 8'(drv[1] & !seed[10]));
            check("select", 8'(sel), 8'(seed[9] ? seed[8] : drv[2]));
            rd(8'h40, {4'h0, seed[11:8]});
        end
        route <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            for (int k = 1; k < 4; k += 2) begin
                cc <= 2'(k);
                wr(8'h20, {m[1:0], 1'b0, m[1:0], 3'h0});
                rd(8'h20, r1);
            end
            cc <= 2'h0;
            for (int g = 0; g < 3; g++)
                pulse(g, g == 0 ? 1 + (m == 3) : 0, g == 0 ? 0 : 1 + (m == 3));
        end
        cc <= 2'h3;
        pulse(0, 0, 0);
        cc <= 2'h0;
        opt <= 8'h00;
        pulse(0, 0, 0);
        for (int c = 0; c < 5; c++) begin
            wr(8'h20, {3'h1, 2'h0, c[1:0], 1'(c < 4)});
            repeat (16) @(posedge sys_clk);
            sa = ne;
            sb = np;
            repeat (32) @(posedge sys_clk);
            check("enables", 8'(ne - sa), 8'(c == 4 ? 32 : 16 >> (2 * c[0] + c[1])));
            check("clk_out", 8'(np - sb), 8'h00);
            check("clk_oe", 8'(poe), 8'h01);
        end
        wr(8'h20, 8'h00);
        #1 check("gpio", {po, poe}, {spi[3], spi[0]});
        end_of_test();
    end
endmodule : misc_irq_clock_spi_ctrl_test

// [misc_pin_partner.sv]
// Pin, spi unit and port logic model facing the control bank
`timescale 1ns/1ps
module misc_pin_partner (
    input  wire logic       sys_clk,
    input  wire logic [2:0] pull_low,
    input  wire logic [3:0] drv,
    output logic [7:0]      pa,
    output logic [7:0]      pb,
    output logic [5:0]      pc,
    output logic [3:0]      spi
);
    // Interrupt pins idle high on their pull-ups unless pulled low
    assign pa = {7'h7f, ~pull_low[0]};
    assign pb = {7'h7f, ~pull_low[1]};
    assign pc = {5'h1f, ~pull_low[2]};
    // Spi enables, select pin and gpio drive move only after an edge
    always_ff @(posedge sys_clk) begin
        spi <= drv;
    end
endmodule : misc_pin_partner

// [pin_irq_detect.sv]
// Synchronises one group of interrupt pins and detects the selected event
`timescale 1ns/1ps
`include "misc_ctrl_cfg.svh"

module pin_irq_detect #(
    parameter int WIDTH = 14
) (
    input  wire logic                        sys_clk,
    input  wire logic                        rst,
    input  wire logic [WIDTH-1:0]            pins,
    input  wire logic [WIDTH-1:0]            qualify,
    input  wire misc_ctrl_pkg::sense_t       sense,
    input  wire logic                        allow,
    output logic                             irq
);
    logic [WIDTH-1:0] rise_ev;
    logic [WIDTH-1:0] fall_ev;
    logic [WIDTH-1:0] low_lvl;
    logic             next_irq;

    // ************************************************************
    // Per-pin synchroniser and edge detector
    // ************************************************************
    for (genvar i = 0; i < WIDTH; i++) begin : g_pin
        logic s1;
        logic s2;
        logic s3;
        logic level;
        logic next_level;
        logic agree;

        // A change counts only once the second and third stages agree
        always_comb begin
            agree      = (s2 == s3);
            next_level = agree ? s3 : level;
            rise_ev[i] = agree && s3 && !level;
            fall_ev[i] = agree && !s3 && level;
            low_lvl[i] = !level;
        end

        // Pins idle high behind their pull-ups
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                s1    <= 1'b1;
                s2    <= 1'b1;
                s3    <= 1'b1;
                level <= 1'b1;
            end else begin
                s1    <= pins[i];
                s2    <= s1;
                s3    <= s2;
                level <= next_level;
            end
        end
    end

    // ************************************************************
    // Sensitivity select
    // ************************************************************
    always_comb begin
        unique case (sense)
            `SENSE_FALL_LOW: next_irq = |(qualify & low_lvl);
            `SENSE_RISE:     next_irq = |(qualify & rise_ev);
            `SENSE_FALL:     next_irq = |(qualify & fall_ev);
            `SENSE_BOTH:     next_irq = |(qualify & (rise_ev | fall_ev));
        endcase
        next_irq = next_irq && allow;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= next_irq;
        end
    end

    a_rise_single: assert property (@(posedge sys_clk) disable iff (rst)
        sense == `SENSE_RISE && $stable(sense) && irq |=> !irq)
        else $error("Rising edge mode gave a request longer than one cycle");
endmodule : pin_irq_detect
